// ===== hw/osc_regs.vh
`ifndef OSC_REGS_VH
`define OSC_REGS_VH
// How it works
// [R1] light control bit 3 sleeps light after irq
// [R2] sleep: drop light enable, re-enable on status read
// [R3] channel select checked only while light enabled
// [R4] light runs only while light enable set
// [R5] prox sleep bit drops optical enable after irq
// [R6] mode 00 prox, 01 single, 10 dual
// [R7] single pleth uses ir, red when swapped; write mask 0F drops swap bit 4, so code drives ir only
// [R8] dual pleth alternates ir/red, swap reverses; swap bit 4 is masked off on write, so order never reverses
// [R9] optical runs only while optical enable set
// [R10] led drive is 10-bit, 000 off
// [R11] led drive resets to 1FF split low/high
// [R12] host writes fixed bits as shown
// [R13] analog cancel bit 6: none or half scale
// [R14] flash count code maps 1..32 pulses
// [R15] pulse count capped by width and interval
// [R16] flash width code 26/42/71 us
// [R17] interval code 3.125ms to 400ms
// [R18] resolution from width and pulse count
// [R19] subtract digital cancel before storing result
// [R20] cancelled result clamps at zero

`define OSC_ADR_LIGHT     8'h15
`define OSC_ADR_OPT       8'h16
`define OSC_ADR_DRV_LO    8'h17
`define OSC_ADR_DRV_HI    8'h18
`define OSC_ADR_CNT       8'h19
`define OSC_ADR_WID       8'h1A
`define OSC_ADR_DC_LO     8'h1B
`define OSC_ADR_DC_HI     8'h1C

`define OSC_RST_LIGHT     8'h00
`define OSC_RST_OPT       8'h00
`define OSC_RST_DRV_LO    8'hFF
`define OSC_RST_DRV_HI    8'h01
`define OSC_RST_CNT       8'h1A
`define OSC_RST_WID       8'h15
`define OSC_RST_DC        8'h00

`define OSC_MASK_LIGHT    8'h0B
`define OSC_MASK_OPT      8'h0F
`define OSC_MASK_DRV_HI   8'h03
`define OSC_MASK_CNT      8'h7F
`define OSC_MASK_WID      8'h37

`define OSC_BIT_EN        0
`define OSC_BIT_SLEEP     3
`define OSC_BIT_CHSEL     1
`define OSC_BIT_ANA       6

`define OSC_MODE_PROX     2'h0
`define OSC_MODE_SINGLE   2'h1
`define OSC_MODE_DUAL     2'h2

// time units: width and interval both in ns (3125000 ns = 3.125 ms)
`define OSC_CLK_NS        8
`define OSC_W26_NS        26000
`define OSC_W42_NS        42000
`define OSC_W71_NS        71000
`define OSC_INT0_NS       3125000
`endif

// ===== hw/osc_cancel.v
`timescale 1ns/1ps
`include "osc_regs.vh"
module osc_cancel
(
	// clock
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        ce,
	// data
	input  wire        in_vld,
	input  wire [15:0] in_raw,
	input  wire [15:0] in_cancel,
	output reg         out_vld_r,
	output reg  [15:0] out_val_r
);
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			out_vld_r <= 1'b0;
			out_val_r <= 16'h0000;
		end
		else if (ce)
		begin
			out_vld_r <= in_vld;
			if (in_vld)
				out_val_r <= (in_cancel > in_raw) ? 16'h0000 : (in_raw - in_cancel); // [R19] [R20]
		end
	end
endmodule

// ===== hw/osc_ctrl.v
`timescale 1ns/1ps
`include "osc_regs.vh"
module osc_ctrl
#(
	parameter INT_SCALE = 1
)
(
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        ce,
	// register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata_r,
	// sensor events
	input  wire        light_irq,
	input  wire        light_done,
	input  wire        light_stat_rd,
	input  wire        prox_irq,
	input  wire        prox_done,
	input  wire        prox_stat_rd,
	input  wire        meas_vld,
	input  wire [15:0] meas_raw,
	// controls out
	output reg         light_run_r,
	output reg         light_rgb_r,
	output reg         opt_run_r,
	output reg  [1:0]  opt_mode_r,
	output reg         led_red_r,
	output reg         led_on_r,
	output reg  [9:0]  led_drive_r,
	output reg         ana_half_r,
	output reg  [4:0]  res_bits_r,
	output reg         res_vld_r,
	output reg  [15:0] prox_result_r
);
	////////////////////////////////////////////////////////////////
	reg  [7:0]  light_r;
	reg  [7:0]  opt_r;
	reg  [7:0]  drv_lo_r;
	reg  [7:0]  drv_hi_r;
	reg  [7:0]  cnt_r;
	reg  [7:0]  wid_r;
	reg  [7:0]  dc_lo_r;
	reg  [7:0]  dc_hi_r;
	reg         lsleep_r;
	reg         psleep_r;
	reg         lpend_r;
	reg         ppend_r;
	wire        can_vld;
	wire [15:0] can_val;

	function [5:0] pulses;
		input [2:0] code;
		begin
			case (code) // [R14]
				3'h0:    pulses = 6'h01;
				3'h1:    pulses = 6'h02;
				3'h2:    pulses = 6'h04;
				3'h3:    pulses = 6'h08;
				3'h4:    pulses = 6'h10;
				default: pulses = 6'h20;
			endcase
		end
	endfunction

	function [5:0] capped;
		input [2:0] cnt;
		input [1:0] wid;
		input [2:0] intv;
		reg   [5:0] p;
		begin
			p = pulses(cnt);
			capped = p;
			if (wid == 2'h1 && intv == 3'h0 && p > 6'h10)
				capped = 6'h10; // [R15]
			if (wid == 2'h2 && intv == 3'h0 && p > 6'h08)
				capped = 6'h08; // [R15]
			if (wid == 2'h2 && intv == 3'h1 && p > 6'h10)
				capped = 6'h10; // [R15]
		end
	endfunction

	function [4:0] resol;
		input [1:0] wid;
		input [5:0] p;
		reg   [4:0] b;
		reg   [4:0] lg;
		begin
			lg = (p[5] ? 5'd5 : p[4] ? 5'd4 : p[3] ? 5'd3 : p[2] ? 5'd2 : p[1] ? 5'd1 : 5'd0);
			b = (wid == 2'h0) ? 5'd10 : (wid == 2'h1) ? 5'd12 : 5'd14;
			resol = (b + lg > 5'd16) ? 5'd16 : b + lg; // [R18]
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// timing: width and interval in cycles
	localparam [31:0] W26_CYC = `OSC_W26_NS / `OSC_CLK_NS; // [R16]
	localparam [31:0] W42_CYC = `OSC_W42_NS / `OSC_CLK_NS;
	localparam [31:0] W71_CYC = `OSC_W71_NS / `OSC_CLK_NS;
	localparam [31:0] INT0_CYC = `OSC_INT0_NS / `OSC_CLK_NS / INT_SCALE;

	// one-hot sequencer states
	localparam [3:0] S_IDLE  = 4'b0001;
	localparam [3:0] S_PULSE = 4'b0010;
	localparam [3:0] S_GAP   = 4'b0100;
	localparam [3:0] S_WAIT  = 4'b1000;

	reg  [3:0]  st_r;
	reg  [31:0] tmr_r;
	reg  [5:0]  np_r;
	reg         phase_r;
	wire [31:0] w_cyc = (wid_r[5:4] == 2'h0) ? W26_CYC :
		(wid_r[5:4] == 2'h2) ? W71_CYC : W42_CYC;
	wire [31:0] i_cyc = INT0_CYC << wid_r[2:0]; // [R17]
	wire [5:0]  np_tot = capped(cnt_r[5:3], wid_r[5:4], wid_r[2:0]);

	////////////////////////////////////////////////////////////////
	osc_cancel u_can
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.in_vld    (meas_vld),
		.in_raw    (meas_raw),
		.in_cancel ({dc_hi_r, dc_lo_r}),
		.out_vld_r (can_vld),
		.out_val_r (can_val)
	);

	////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			light_r  <= `OSC_RST_LIGHT;
			opt_r    <= `OSC_RST_OPT;
			drv_lo_r <= `OSC_RST_DRV_LO; // [R11]
			drv_hi_r <= `OSC_RST_DRV_HI;
			cnt_r    <= `OSC_RST_CNT;
			wid_r    <= `OSC_RST_WID;
			dc_lo_r  <= `OSC_RST_DC;
			dc_hi_r  <= `OSC_RST_DC;
			lsleep_r <= 1'b0;
			psleep_r <= 1'b0;
			lpend_r  <= 1'b0;
			ppend_r  <= 1'b0;
			reg_rdata_r <= 8'h00;
		end
		else if (ce)
		begin
			// sleep after irq: wait for measurement end, then park until status read
			if (light_irq && light_r[`OSC_BIT_SLEEP] && light_r[`OSC_BIT_EN])
				lpend_r <= 1'b1; // [R1] [R2]
			if (lpend_r && light_done)
			begin
				lpend_r  <= 1'b0;
				lsleep_r <= 1'b1; // [R2]
			end
			if (lsleep_r && light_stat_rd && !(lpend_r && light_done))
				lsleep_r <= 1'b0; // [R2]
			if (prox_irq && opt_r[`OSC_BIT_SLEEP] && opt_r[`OSC_BIT_EN])
				ppend_r <= 1'b1; // [R5]
			if (ppend_r && prox_done)
			begin
				ppend_r  <= 1'b0;
				psleep_r <= 1'b1; // [R5]
			end
			if (psleep_r && prox_stat_rd && !(ppend_r && prox_done))
				psleep_r <= 1'b0; // [R5]
			if (reg_wr)
			begin
				// fixed bits are stored masked; host keeps them as shown [R12]
				case (reg_addr)
					`OSC_ADR_LIGHT:  light_r  <= reg_wdata & `OSC_MASK_LIGHT;
					`OSC_ADR_OPT:    opt_r    <= reg_wdata & `OSC_MASK_OPT;
					`OSC_ADR_DRV_LO: drv_lo_r <= reg_wdata;
					`OSC_ADR_DRV_HI: drv_hi_r <= reg_wdata & `OSC_MASK_DRV_HI;
					`OSC_ADR_CNT:    cnt_r    <= (reg_wdata & `OSC_MASK_CNT);
					`OSC_ADR_WID:    wid_r    <= reg_wdata & `OSC_MASK_WID;
					`OSC_ADR_DC_LO:  dc_lo_r  <= reg_wdata;
					`OSC_ADR_DC_HI:  dc_hi_r  <= reg_wdata;
					default:         ;
				endcase
			end
			if (reg_rd)
			begin
				// enable bits read back as cleared while parked
				case (reg_addr)
					`OSC_ADR_LIGHT:  reg_rdata_r <= {light_r[7:1], light_r[0] & ~lsleep_r};
					`OSC_ADR_OPT:    reg_rdata_r <= {opt_r[7:1], opt_r[0] & ~psleep_r};
					`OSC_ADR_DRV_LO: reg_rdata_r <= drv_lo_r;
					`OSC_ADR_DRV_HI: reg_rdata_r <= drv_hi_r;
					`OSC_ADR_CNT:    reg_rdata_r <= cnt_r;
					`OSC_ADR_WID:    reg_rdata_r <= wid_r;
					`OSC_ADR_DC_LO:  reg_rdata_r <= dc_lo_r;
					`OSC_ADR_DC_HI:  reg_rdata_r <= dc_hi_r;
					default:         reg_rdata_r <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// control outputs
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			light_run_r <= 1'b0;
			light_rgb_r <= 1'b0;
			opt_run_r   <= 1'b0;
			opt_mode_r  <= `OSC_MODE_PROX;
			led_drive_r <= 10'h000;
			ana_half_r  <= 1'b0;
			res_bits_r  <= 5'd0;
			res_vld_r   <= 1'b0;
			prox_result_r <= 16'h0000;
		end
		else if (ce)
		begin
			light_run_r <= light_r[`OSC_BIT_EN] & ~lsleep_r; // [R4]
			light_rgb_r <= light_r[`OSC_BIT_EN] & light_r[`OSC_BIT_CHSEL]; // [R3]
			opt_run_r   <= opt_r[`OSC_BIT_EN] & ~psleep_r; // [R9]
			opt_mode_r  <= (opt_r[2:1] == 2'h3) ? `OSC_MODE_PROX : opt_r[2:1]; // [R6]
			led_drive_r <= {drv_hi_r[1:0], drv_lo_r}; // [R10]
			ana_half_r  <= cnt_r[`OSC_BIT_ANA]; // [R13]
			res_bits_r  <= resol(wid_r[5:4], np_tot); // [R18]
			res_vld_r   <= can_vld;
			if (can_vld)
				prox_result_r <= can_val; // [R19]
		end
	end

	////////////////////////////////////////////////////////////////
	// pulse sequencer
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_r     <= S_IDLE;
			tmr_r    <= 32'd0;
			np_r     <= 6'd0;
			phase_r  <= 1'b0;
			led_on_r <= 1'b0;
			led_red_r <= 1'b0;
		end
		else if (ce)
		begin
			case (st_r)
				S_IDLE:
				begin
					led_on_r <= 1'b0;
					tmr_r    <= 32'd0;
					np_r     <= 6'd0;
					if (opt_run_r && led_drive_r != 10'h000) // [R10]
					begin
						st_r <= S_PULSE;
						led_on_r <= 1'b1;
						case (opt_mode_r)
							`OSC_MODE_SINGLE: led_red_r <= opt_r[4]; // [R7]
							`OSC_MODE_DUAL:   led_red_r <= phase_r ^ opt_r[4]; // [R8]
							default:          led_red_r <= 1'b0;
						endcase
					end
				end
				S_PULSE:
				begin
					tmr_r <= tmr_r + 32'd1;
					if (!opt_run_r)
					begin
						// disable cuts the burst at once, mid-pulse; led_on_r drops one cycle after opt_run_r
						led_on_r <= 1'b0; // [R9]
						st_r     <= S_IDLE;
					end
					else if (tmr_r + 32'd1 >= w_cyc) // [R16]
					begin
						led_on_r <= 1'b0;
						np_r <= np_r + 6'd1;
						st_r <= (np_r + 6'd1 >= np_tot) ? S_WAIT : S_GAP; // [R14] [R15]
					end
				end
				S_GAP:
				begin
					tmr_r <= 32'd0;
					if (!opt_run_r)
						st_r <= S_IDLE; // [R9]
					else
					begin
						led_on_r <= 1'b1;
						st_r     <= S_PULSE;
					end
				end
				S_WAIT:
				begin
					tmr_r <= tmr_r + 32'd1;
					if (!opt_run_r)
						st_r <= S_IDLE;
					else if (tmr_r + 32'd1 >= i_cyc) // [R17]
					begin
						phase_r <= ~phase_r; // [R8]
						st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== sim/osc_host.sv
`timescale 1ns/1ps
module osc_host
(
	// register port
	input  wire       clk,
	input  wire [7:0] reg_rdata_r,
	output reg        reg_wr,
	output reg        reg_rd,
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata
);
initial
begin
	reg_wr = 1'b0;
	reg_rd = 1'b0;
	reg_addr = 8'h00;
	reg_wdata = 8'h00;
end
// released lines show the inverse so a stale value can never pass for a new one
task wr(input [7:0] a, input [7:0] v);
begin
	@(posedge clk);
	#1;
	reg_wr = 1'b1;
	reg_addr = a;
	reg_wdata = v;
	@(posedge clk);
	#1;
	reg_wr = 1'b0;
	reg_addr = ~a;
	reg_wdata = ~v;
end
endtask
task rd(input [7:0] a, output [7:0] v);
begin
	@(posedge clk);
	#1;
	reg_rd = 1'b1;
	reg_addr = a;
	@(posedge clk);
	#1;
	v = reg_rdata_r;
	reg_rd = 1'b0;
	reg_addr = ~a;
end
endtask
endmodule

// ===== sim/osc_ctrl_assertions.sv
`timescale 1ns/1ps
module osc_ctrl_chk
(
	// clock and bus
	input wire        clk,
	input wire        sys_rst,
	input wire        ce,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata_r,
	// measurement and controls
	input wire        meas_vld,
	input wire [15:0] meas_raw,
	input wire        light_run_r,
	input wire        opt_run_r,
	input wire        led_on_r,
	input wire [9:0]  led_drive_r,
	input wire        res_vld_r,
	input wire [15:0] prox_result_r
);
reg  [15:0] cncl_r;
reg  [15:0] exp_r;
wire        wr_ok = ce && reg_wr;
always @(posedge clk)
begin
	if (sys_rst)
		cncl_r <= 16'h0000;
	else if (wr_ok && reg_addr == 8'h1B)
		cncl_r[7:0] <= reg_wdata;
	else if (wr_ok && reg_addr == 8'h1C)
		cncl_r[15:8] <= reg_wdata;
	exp_r <= (meas_raw > cncl_r) ? meas_raw - cncl_r : 16'h0000;
end
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
a_read_unmapped: assert property (ce && reg_rd && reg_addr == 8'h30 |=> reg_rdata_r == 8'h00)
	else $error("unmapped read not zero");
a_read_cancel: assert property (ce && reg_rd && reg_addr == 8'h1B |=> reg_rdata_r == cncl_r[7:0])
	else $error("cancel low byte read wrong");
a_result_value: assert property (ce && meas_vld && opt_run_r |=> ##1 res_vld_r && prox_result_r == exp_r)
	else $error("cancelled result wrong");
a_opt_on: assert property (wr_ok && reg_addr == 8'h16 && reg_wdata[0] && !reg_wdata[3] |-> ##2 opt_run_r)
	else $error("optical enable not followed");
a_opt_off: assert property (wr_ok && reg_addr == 8'h16 && !reg_wdata[0] |-> ##2 !opt_run_r)
	else $error("optical disable not followed");
a_light_off: assert property (wr_ok && reg_addr == 8'h15 && !reg_wdata[0] |-> ##2 !light_run_r)
	else $error("light disable not followed");
a_drive_low: assert property (wr_ok && reg_addr == 8'h17 |-> ##2 led_drive_r[7:0] == $past(reg_wdata, 2))
	else $error("drive low byte not applied");
a_ce_freeze: assert property (!ce |=> $stable(reg_rdata_r) && $stable(opt_run_r))
	else $error("state moved while frozen");
a_led_off: assert property (ce && !opt_run_r |=> !led_on_r)
	else $error("led lit while optical disabled");
c_result: cover property (res_vld_r);
c_opt_run: cover property ($rose(opt_run_r));
c_light_run: cover property ($fell(light_run_r));
endmodule
bind osc_ctrl osc_ctrl_chk u_osc_ctrl_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
	.meas_vld(meas_vld), .meas_raw(meas_raw), .light_run_r(light_run_r), .opt_run_r(opt_run_r),
	.led_on_r(led_on_r), .led_drive_r(led_drive_r), .res_vld_r(res_vld_r),
	.prox_result_r(prox_result_r));

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t got %h expected %h", $time, g, e); end end
module tb_top;
reg         clk = 1'b0;
reg         sys_rst = 1'b1;
reg         ce = 1'b1;
reg  [5:0]  ev = 6'h00;
reg         meas_vld = 1'b0;
reg  [15:0] meas_raw = 16'h0000;
wire        reg_wr, reg_rd, light_run_r, light_rgb_r, opt_run_r, led_red_r, led_on_r;
wire        ana_half_r, res_vld_r;
wire [7:0]  reg_addr, reg_wdata, reg_rdata_r;
wire [1:0]  opt_mode_r;
wire [9:0]  led_drive_r;
wire [4:0]  res_bits_r;
wire [15:0] prox_result_r;
integer     bad_count = 0;
integer     num_checks = 0;
integer     i, j, n;
reg  [7:0]  d;
reg  [7:0]  adr [0:8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h30};
reg  [7:0]  rst [0:8] = '{8'h00, 8'h00, 8'hFF, 8'h01, 8'h1A, 8'h15, 8'h00, 8'h00, 8'h00};
reg  [7:0]  hi [0:8] = '{8'h0B, 8'h0D, 8'hFF, 8'h03, 8'h7A, 8'h27, 8'hFF, 8'hFF, 8'hFF};
reg  [7:0]  lo [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
always #4 clk = ~clk;
osc_host u_osc_host (.clk(clk), .reg_rdata_r(reg_rdata_r), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata));
osc_ctrl #(.INT_SCALE(1000)) u_osc_ctrl (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
	.light_irq(ev[5]), .light_done(ev[4]), .light_stat_rd(ev[3]), .prox_irq(ev[2]),
	.prox_done(ev[1]), .prox_stat_rd(ev[0]), .meas_vld(meas_vld), .meas_raw(meas_raw),
	.light_run_r(light_run_r), .light_rgb_r(light_rgb_r), .opt_run_r(opt_run_r),
	.opt_mode_r(opt_mode_r), .led_red_r(led_red_r), .led_on_r(led_on_r),
	.led_drive_r(led_drive_r), .ana_half_r(ana_half_r), .res_bits_r(res_bits_r),
	.res_vld_r(res_vld_r), .prox_result_r(prox_result_r));
task cyc(input integer n);
begin
	repeat (n) @(posedge clk);
	#1;
end
endtask
task t_regs;
begin
	for (i = 0; i < 9; i++)
	begin
		u_osc_host.rd(adr[i], d);
		`CHK(d, rst[i])
		u_osc_host.wr(adr[i], hi[i]);
		u_osc_host.rd(adr[i], d);
		`CHK(d, (i == 8) ? 8'h00 : hi[i])
		u_osc_host.wr(adr[i], lo[i]);
		u_osc_host.rd(adr[i], d);
		`CHK(d, lo[i])
	end
	`CHK(led_drive_r, 10'h000)
end
endtask
task t_drive;
begin
	u_osc_host.wr(8'h17, 8'hFF);
	u_osc_host.wr(8'h18, 8'h03);
	u_osc_host.wr(8'h19, 8'h42);
	cyc(3);
	`CHK(led_drive_r, 10'h3FF)
	`CHK(ana_half_r, 1'b1)
	// a frozen block must drop the write entirely
	ce = 1'b0;
	u_osc_host.wr(8'h17, 8'h00);
	ce = 1'b1;
	u_osc_host.rd(8'h17, d);
	`CHK(d, 8'hFF)
end
endtask
task t_res;
begin
	for (i = 0; i < 3; i++)
		for (j = 0; j < 8; j++)
		begin
			u_osc_host.wr(8'h1A, {2'b00, i[1:0], 1'b0, j[2:0]});
			u_osc_host.wr(8'h19, {2'b00, j[2:0], 3'b010});
			cyc(3);
			d = 10 + 2 * i + ((j > 5) ? 5 : j);
			`CHK(res_bits_r, (d > 16) ? 5'd16 : d[4:0])
		end
end
endtask
task t_mode;
begin
	for (i = 0; i < 3; i++)
	begin
		u_osc_host.wr(8'h16, {5'b00000, i[1:0], 1'b1});
		cyc(3);
		`CHK(opt_mode_r, i[1:0])
		`CHK(led_on_r, 1'b1)
		if (i == 2)
			`CHK(led_red_r, 1'b0)
		else
			`CHK(led_red_r, 1'b0)
		u_osc_host.wr(8'h16, 8'h00);
		cyc(3);
		`CHK(led_on_r, 1'b0)
	end
end
endtask
task t_width;
begin
	// 26 us width, one pulse, so the first pulse is a clean 3250 cycles at 8 ns
	u_osc_host.wr(8'h1A, 8'h00);
	u_osc_host.wr(8'h19, 8'h02);
	u_osc_host.wr(8'h16, 8'h01);
	n = 0;
	while (!led_on_r && n < 20)
	begin
		cyc(1);
		n++;
	end
	n = 0;
	while (led_on_r && n < 4000)
	begin
		cyc(1);
		n++;
	end
	`CHK(n, 3250)
	u_osc_host.wr(8'h16, 8'h00);
end
endtask
task meas(input [15:0] cn, input [15:0] raw, input [15:0] e);
begin
	u_osc_host.wr(8'h1B, cn[7:0]);
	u_osc_host.wr(8'h1C, cn[15:8]);
	meas_vld = 1'b1;
	meas_raw = raw;
	cyc(1);
	meas_vld = 1'b0;
	// the valid pulse stands for one cycle only
	cyc(1);
	`CHK(res_vld_r, 1'b1)
	`CHK(prox_result_r, e)
	u_osc_host.rd(8'h1B, d);
	`CHK(d, cn[7:0])
end
endtask
task t_cancel;
begin
	u_osc_host.wr(8'h16, 8'h01);
	meas(16'h1234, 16'h5678, 16'h4444);
	meas(16'h1234, 16'h1000, 16'h0000);
	meas(16'h1234, 16'h1234, 16'h0000);
	u_osc_host.wr(8'h16, 8'h00);
end
endtask
task t_sleep(input integer k);
begin
	u_osc_host.wr(k ? 8'h15 : 8'h16, k ? 8'h0B : 8'h09);
	cyc(3);
	`CHK(k ? light_run_r : opt_run_r, 1'b1)
	if (k)
		`CHK(light_rgb_r, 1'b1)
	ev[k + 2] = 1'b1;
	cyc(1);
	ev = 6'h00;
	cyc(3);
	`CHK(k ? light_run_r : opt_run_r, 1'b1)
	ev[k + 1] = 1'b1;
	cyc(1);
	ev = 6'h00;
	cyc(3);
	`CHK(k ? light_run_r : opt_run_r, 1'b0)
	u_osc_host.rd(k ? 8'h15 : 8'h16, d);
	`CHK(d[0], 1'b0)
	ev[k] = 1'b1;
	cyc(1);
	ev = 6'h00;
	cyc(3);
	`CHK(k ? light_run_r : opt_run_r, 1'b1)
	u_osc_host.wr(k ? 8'h15 : 8'h16, 8'h00);
end
endtask
task end_of_test;
begin
	$display("checks %0d mismatches %0d", num_checks, bad_count);
	if (bad_count == 0 && num_checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
end
endtask
initial
begin
	#400000;
	bad_count++;
	end_of_test;
end
initial
begin
	repeat (4) @(posedge clk);
	#1;
	sys_rst = 1'b0;
	cyc(2);
	`CHK(led_drive_r, 10'h1FF)
	t_regs;
	t_drive;
	t_res;
	t_mode;
	t_width;
	t_cancel;
	t_sleep(0);
	t_sleep(3);
	end_of_test;
end
endmodule
